// File: core/bpc_core.sv
// Batch preset counter: scaling, batch control, rate, analogue and pulse output
// How it works
// - Start turns on prewarn and final relays together in one cycle.
// - Prewarn relay drops at prewarn count, final relay drops at preset count.
// - Prewarn larger than preset raises an ordering error flag.
// - Rate sampled over 2 to 24 seconds, result kept to bounded digits.
// - Rate factor one gives input pulses per second; others rescale.
// - Scaling factor divides input pulses; eight digits, movable decimal point.
// - Count path and rate path have separate scaling factors.
// - Factored count handles 20 kHz; rate result capped at seven digits.
// - Batch count to 99999999; counts up from zero or down from preset.
// - Grand total runs apart; clear while shown clears only it.
// - Four digit code locks settings; refused changes flagged; same code unlocks.
// - Analogue value maps rate or total linearly between low and high.
// - One output pulse per factored count at 10/200/2000/20000 per second.
// - Up to 9999 queued counts; overflow sets a lost-data flag.
// - Batch reset leaves queued output counts to drain at selected rate.
// - Fixed preset mode: preset set only in programming, clear before new batch.
// - Quick preset mode: preset writable in run state, restart without reset.
// - Counting continues before a batch starts and after it ends.
// - Fixed mode completion drops both relays and shows the batched amount.
// - Stop drops both relays keeping count; start resumes the same batch.
// - Quick mode completion flashes preset; typed value replaces it; enter returns.
// - Clear resets the displayed count and returns relays to reset state.
`timescale 1ns/10ps

module bpc_core #(
	parameter int unsigned SEC_CYCLES = bpc_pkg::RATE_TICK_CYC,
	parameter int unsigned HALF_10    = bpc_pkg::HALF_CYC_0,
	parameter int unsigned HALF_200   = bpc_pkg::HALF_CYC_1,
	parameter int unsigned HALF_2000  = bpc_pkg::HALF_CYC_2
) (
	// Clock and reset
	input  wire logic                  CLOCK,
	input  wire logic                  ARST_N,
	// Flowmeter pulse input
	input  wire logic                  FLOW_PULSE,
	// Register port
	input  wire bpc_pkg::bpc_bus_req_t BUS_REQ,
	output logic [31:0]                RDATA,
	// Relay drivers and factored pulse output
	output bpc_pkg::bpc_relay_t        RELAYS,
	output logic                       PULSE_OUT,
	// Analogue output code
	output logic [15:0]                ANALOG_OUT,
	// Display indications
	output logic                       PREWARN_ORDER_ERROR,
	output logic                       OUTPUT_OVERFLOW_FLAG,
	output logic                       LOCK_ON,
	output logic                       PRESET_FLASH
);

	typedef struct packed {
		bpc_pkg::bpc_state_t state;
		bpc_pkg::bpc_disp_t  disp;
		logic                grand_shown;
		logic                armed;
		logic                flash;
		logic                locked;
		logic                lock_refused;
		logic                overflow;
		logic                pw_err;
		bpc_pkg::bpc_relay_t relay;
		logic                flow_prev;
		logic                count_down;
		logic                quick;
		logic                asrc;
		logic [1:0]          speed;
		logic [4:0]          win;
		logic [31:0]         preset;
		logic [31:0]         prewarn;
		logic [31:0]         ckf;
		logic [31:0]         rkf;
		logic [31:0]         ana_lo;
		logic [31:0]         ana_hi;
		logic [15:0]         lock_code;
		logic [31:0]         count;
		logic [31:0]         grand;
		logic [39:0]         cacc;
		logic [39:0]         racc;
		logic [31:0]         rcnt;
		logic [31:0]         rate;
		logic [31:0]         tick;
		logic [4:0]          wsec;
		logic [13:0]         buf_lvl;
		logic [31:0]         phase;
		logic                pbusy;
		logic                pulse;
		logic                ana_busy;
		logic [4:0]          ana_i;
		logic [32:0]         ana_rem;
		logic [31:0]         ana_den;
		logic [15:0]         ana_q;
		logic [15:0]         ana_out;
		logic [31:0]         rdata;
	} bpc_core_st_t;

	bpc_core_st_t st_reg;
	bpc_core_st_t st_next;

	logic        flow_edge;
	logic [39:0] c_thr;
	logic [39:0] r_thr;
	logic [39:0] c_inc;
	logic [39:0] r_inc;
	logic        c_emit;
	logic        r_emit;
	logic [31:0] pw_level;
	logic        pw_hit;
	logic        fin_hit;
	logic [31:0] half_sel;
	logic        pulse_done;
	logic        cfg_ok;
	logic        preset_ok;
	logic        is_wr;
	logic [31:0] cmd;
	logic [31:0] ana_src;
	logic [31:0] ana_num;
	logic [31:0] ana_dw;
	logic [32:0] rem_sh;
	logic [31:0] disp_val;
	logic [31:0] status_w;
	logic [31:0] reload;

	// Ten to the power of the decimal places, at most five: the per-pulse weight of a factor
	function automatic logic [39:0] pow10(input logic [3:0] dp);
		logic [39:0] v;
		v = 40'h00_0000_0001;
		for (int k = 0; k < 5; k++) begin
			if (k < int'(dp)) begin
				v = 40'((v << 3) + (v << 1));
			end
		end
		return v;
	endfunction : pow10

	// Scaling: a factor K = mantissa / 10^dp divides pulses by counting in 10^dp units
	assign flow_edge = FLOW_PULSE & ~st_reg.flow_prev;
	assign c_thr = (st_reg.ckf[bpc_pkg::KF_MANT_W-1:0] == '0) ? 40'h00_0000_0001 :
		40'(st_reg.ckf[bpc_pkg::KF_MANT_W-1:0]);
	assign r_thr = (st_reg.rkf[bpc_pkg::KF_MANT_W-1:0] == '0) ? 40'(st_reg.win) :
		40'(st_reg.rkf[bpc_pkg::KF_MANT_W-1:0]) * 40'(st_reg.win);
	assign c_inc = pow10(st_reg.ckf[bpc_pkg::KF_DP+3:bpc_pkg::KF_DP]);
	assign r_inc = pow10(st_reg.rkf[bpc_pkg::KF_DP+3:bpc_pkg::KF_DP]);
	assign c_emit = st_reg.cacc >= c_thr;
	assign r_emit = st_reg.racc >= r_thr;

	// Preset compare; counting down compares against the remaining amount
	assign pw_level = st_reg.pw_err ? '0 : st_reg.preset - st_reg.prewarn;
	assign pw_hit = st_reg.count_down ? (st_reg.count <= pw_level) :
		(st_reg.count >= st_reg.prewarn);
	assign fin_hit = st_reg.count_down ? (st_reg.count == '0) :
		(st_reg.count >= st_reg.preset);
	assign reload = st_reg.count_down ? st_reg.preset : '0;

	// Output pulse half period by selected speed
	always_comb begin
		unique case (st_reg.speed)
			2'b00: half_sel = HALF_10;
			2'b01: half_sel = HALF_200;
			2'b10: half_sel = HALF_2000;
			2'b11: half_sel = bpc_pkg::HALF_CYC_3;
		endcase
	end
	assign pulse_done = st_reg.pbusy & ~st_reg.pulse & (st_reg.phase == half_sel - 32'h1);

	// Register port decode helpers
	assign is_wr = BUS_REQ.wr;
	assign cmd = (is_wr && BUS_REQ.addr == bpc_pkg::OFS_CMD) ? BUS_REQ.wdata : '0;
	assign cfg_ok = ~st_reg.locked & (st_reg.state == bpc_pkg::ST_PROGRAM);
	assign preset_ok = ~st_reg.locked & ((st_reg.state == bpc_pkg::ST_PROGRAM) |
		st_reg.quick);

	// Analogue mapping operands
	assign ana_src = st_reg.asrc ? st_reg.count : st_reg.rate;
	assign ana_num = (ana_src > st_reg.ana_lo) ? ana_src - st_reg.ana_lo : '0;
	assign ana_dw = (st_reg.ana_hi > st_reg.ana_lo) ? st_reg.ana_hi - st_reg.ana_lo : '0;
	assign rem_sh = {st_reg.ana_rem[31:0], 1'b0};

	// Display selection and status word
	always_comb begin
		if (st_reg.grand_shown) begin
			disp_val = st_reg.grand;
		end else begin
			unique case (st_reg.disp)
				bpc_pkg::DSP_RATE:   disp_val = st_reg.rate;
				bpc_pkg::DSP_PRESET: disp_val = st_reg.preset;
				default:             disp_val = st_reg.count;
			endcase
		end
	end
	assign status_w = {21'h0, st_reg.grand_shown, st_reg.disp, st_reg.flash,
		st_reg.lock_refused, st_reg.locked, st_reg.overflow, st_reg.pw_err, st_reg.state};

	// Next state of the whole block
	always_comb begin
		st_next = st_reg;
		st_next.flow_prev = FLOW_PULSE;
		st_next.pw_err = st_reg.prewarn > st_reg.preset;

		// Factored count path; one count per cycle keeps far ahead of 20 kHz
		st_next.cacc = st_reg.cacc + (flow_edge ? c_inc : '0) - (c_emit ? c_thr : '0);
		st_next.racc = st_reg.racc + (flow_edge ? r_inc : '0) - (r_emit ? r_thr : '0);
		if (c_emit) begin
			if (st_reg.count_down) begin
				if (st_reg.count != '0) st_next.count = st_reg.count - 32'h1;
			end else if (st_reg.count < bpc_pkg::COUNT_MAX) begin
				st_next.count = st_reg.count + 32'h1;
			end
			if (st_reg.grand < bpc_pkg::COUNT_MAX) begin
				st_next.grand = st_reg.grand + 32'h1;
			end
		end

		// Rate window: threshold already includes the window, so counts are per second
		if (r_emit) st_next.rcnt = st_reg.rcnt + 32'h1;
		if (st_reg.tick >= SEC_CYCLES - 1) begin
			st_next.tick = '0;
			if (st_reg.wsec + 5'h1 >= st_reg.win) begin
				st_next.wsec = '0;
				st_next.rcnt = r_emit ? 32'h1 : '0;
				st_next.rate = (st_reg.rcnt > bpc_pkg::RATE_MAX) ?
					bpc_pkg::RATE_MAX : st_reg.rcnt;
			end else begin
				st_next.wsec = st_reg.wsec + 5'h1;
			end
		end else begin
			st_next.tick = st_reg.tick + 32'h1;
		end

		// Output queue; a batch clear never touches it, so queued counts still drain
		if (c_emit && !pulse_done && st_reg.buf_lvl == bpc_pkg::BUF_MAX) begin
			st_next.overflow = 1'b1;
		end else if (c_emit && !pulse_done) begin
			st_next.buf_lvl = st_reg.buf_lvl + 14'h1;
		end else if (!c_emit && pulse_done) begin
			st_next.buf_lvl = st_reg.buf_lvl - 14'h1;
		end

		// Pulse generator: high half then low half per queued count
		if (!st_reg.pbusy) begin
			if (st_reg.buf_lvl != '0) begin
				st_next.pbusy = 1'b1;
				st_next.pulse = 1'b1;
				st_next.phase = '0;
			end
		end else if (st_reg.phase == half_sel - 32'h1) begin
			st_next.phase = '0;
			st_next.pulse = 1'b0;
			if (!st_reg.pulse) st_next.pbusy = 1'b0;
		end else begin
			st_next.phase = st_reg.phase + 32'h1;
		end

		// Analogue map: 16 step restoring division of the span position
		if (!st_reg.ana_busy) begin
			if (ana_dw == '0) begin
				st_next.ana_out = (ana_num != '0) ? bpc_pkg::ANA_FULL : '0;
			end else if (ana_num >= ana_dw) begin
				st_next.ana_out = bpc_pkg::ANA_FULL;
			end else begin
				st_next.ana_busy = 1'b1;
				st_next.ana_rem = {1'b0, ana_num};
				st_next.ana_den = ana_dw;
				st_next.ana_i = bpc_pkg::DIV_STEPS;
				st_next.ana_q = '0;
			end
		end else begin
			if (rem_sh >= {1'b0, st_reg.ana_den}) begin
				st_next.ana_rem = rem_sh - {1'b0, st_reg.ana_den};
				st_next.ana_q = {st_reg.ana_q[14:0], 1'b1};
			end else begin
				st_next.ana_rem = rem_sh;
				st_next.ana_q = {st_reg.ana_q[14:0], 1'b0};
			end
			st_next.ana_i = st_reg.ana_i - 5'h1;
			if (st_reg.ana_i == 5'h1) begin
				st_next.ana_busy = 1'b0;
				st_next.ana_out = st_next.ana_q;
			end
		end

		// Batch progress while running
		if (st_reg.state == bpc_pkg::ST_RUNNING) begin
			if (fin_hit) begin
				st_next.relay = '0;
				st_next.state = bpc_pkg::ST_DONE;
				st_next.armed = 1'b0;
				st_next.grand_shown = 1'b0;
				if (st_reg.quick) begin
					st_next.flash = 1'b1;
					st_next.disp = bpc_pkg::DSP_PRESET;
				end else begin
					st_next.disp = bpc_pkg::DSP_TOTAL;
				end
			end else if (pw_hit) begin
				st_next.relay.prewarn = 1'b0;
			end
		end

		// Flag clear keeps a same-cycle overflow and precedes the register writes, so an event in the same cycle still wins
		if (cmd[bpc_pkg::CMD_FCLR]) begin
			st_next.overflow = c_emit && !pulse_done && st_reg.buf_lvl == bpc_pkg::BUF_MAX;
			st_next.lock_refused = 1'b0;
		end

		// Commands; clear outranks stop, which outranks start
		if (cmd[bpc_pkg::CMD_CLEAR] && st_reg.state != bpc_pkg::ST_PROGRAM) begin
			if (st_reg.grand_shown) begin
				st_next.grand = '0;
			end else if (st_reg.disp == bpc_pkg::DSP_PRESET) begin
				if (preset_ok) st_next.preset = '0;
			end else begin
				st_next.count = reload;
				st_next.relay = '0;
				st_next.state = bpc_pkg::ST_IDLE;
				st_next.armed = 1'b1;
				st_next.flash = 1'b0;
			end
		end else if (cmd[bpc_pkg::CMD_STOP] && st_reg.state == bpc_pkg::ST_RUNNING) begin
			st_next.relay = '0;
			st_next.state = bpc_pkg::ST_STOPPED;
		end else if (cmd[bpc_pkg::CMD_START]) begin
			if (st_reg.state == bpc_pkg::ST_STOPPED) begin
				st_next.relay = '{prewarn: 1'b1, final_out: 1'b1};
				st_next.state = bpc_pkg::ST_RUNNING;
			end else if (st_reg.quick && (st_reg.state == bpc_pkg::ST_IDLE ||
				st_reg.state == bpc_pkg::ST_DONE)) begin
				st_next.count = reload;
				st_next.flash = 1'b0;
				st_next.relay = '{prewarn: 1'b1, final_out: 1'b1};
				st_next.state = bpc_pkg::ST_RUNNING;
			end else if (st_reg.state == bpc_pkg::ST_IDLE && st_reg.armed) begin
				st_next.armed = 1'b0;
				st_next.relay = '{prewarn: 1'b1, final_out: 1'b1};
				st_next.state = bpc_pkg::ST_RUNNING;
			end
		end

		// Menu, enter and display keys
		if (cmd[bpc_pkg::CMD_MENU]) begin
			st_next.relay = '0;
			st_next.state = bpc_pkg::ST_PROGRAM;
			st_next.grand_shown = 1'b0;
		end else if (cmd[bpc_pkg::CMD_ENTER]) begin
			if (st_reg.state == bpc_pkg::ST_PROGRAM) begin
				st_next.state = bpc_pkg::ST_IDLE;
			end else if (st_reg.flash) begin
				st_next.flash = 1'b0;
				st_next.disp = bpc_pkg::DSP_TOTAL;
			end else if (st_reg.disp == bpc_pkg::DSP_TOTAL) begin
				st_next.grand_shown = ~st_reg.grand_shown;
			end
		end else if (cmd[bpc_pkg::CMD_DISP]) begin
			st_next.grand_shown = 1'b0;
			unique case (st_reg.disp)
				bpc_pkg::DSP_TOTAL:  st_next.disp = bpc_pkg::DSP_RATE;
				bpc_pkg::DSP_RATE:   st_next.disp = st_reg.quick ?
					bpc_pkg::DSP_PRESET : bpc_pkg::DSP_TOTAL;
				default:             st_next.disp = bpc_pkg::DSP_TOTAL;
			endcase
		end

		// Register writes; settings only in programming (preset also in quick mode) and only while unlocked
		if (is_wr) begin
			unique case (BUS_REQ.addr)
				bpc_pkg::OFS_CTRL, bpc_pkg::OFS_PREWARN, bpc_pkg::OFS_CKF,
				bpc_pkg::OFS_RKF, bpc_pkg::OFS_ANA_LO, bpc_pkg::OFS_ANA_HI: begin
					if (st_reg.locked) st_next.lock_refused = 1'b1;
					if (cfg_ok) begin
						unique case (BUS_REQ.addr)
							bpc_pkg::OFS_CTRL: begin
								st_next.count_down = BUS_REQ.wdata[bpc_pkg::CTRL_DOWN];
								st_next.quick = BUS_REQ.wdata[bpc_pkg::CTRL_QUICK];
								st_next.asrc = BUS_REQ.wdata[bpc_pkg::CTRL_ASRC];
								st_next.speed = BUS_REQ.wdata[bpc_pkg::CTRL_SPD +: 2];
								st_next.win = BUS_REQ.wdata[bpc_pkg::CTRL_WIN +: 5];
								if (st_next.win < bpc_pkg::WIN_MIN) begin
									st_next.win = bpc_pkg::WIN_MIN;
								end else if (st_next.win > bpc_pkg::WIN_MAX) begin
									st_next.win = bpc_pkg::WIN_MAX;
								end
							end
							bpc_pkg::OFS_PREWARN: st_next.prewarn = BUS_REQ.wdata;
							bpc_pkg::OFS_CKF:     st_next.ckf = BUS_REQ.wdata;
							bpc_pkg::OFS_RKF:     st_next.rkf = BUS_REQ.wdata;
							bpc_pkg::OFS_ANA_LO:  st_next.ana_lo = BUS_REQ.wdata;
							default:              st_next.ana_hi = BUS_REQ.wdata;
						endcase
					end
				end
				bpc_pkg::OFS_PRESET: begin
					if (st_reg.locked) begin
						st_next.lock_refused = 1'b1;
					end else if (preset_ok) begin
						st_next.preset = BUS_REQ.wdata;
					end
				end
				bpc_pkg::OFS_LOCK: begin
					if (!st_reg.locked) begin
						st_next.locked = 1'b1;
						st_next.lock_code = BUS_REQ.wdata[15:0];
					end else if (BUS_REQ.wdata[15:0] == st_reg.lock_code) begin
						st_next.locked = 1'b0;
					end else begin
						st_next.lock_refused = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// Read data stands only in the cycle after the read strobe
		st_next.rdata = '0;
		if (BUS_REQ.rd) begin
			unique case (BUS_REQ.addr)
				bpc_pkg::OFS_CTRL: st_next.rdata = {19'h0, st_reg.win, 3'h0, st_reg.speed,
					st_reg.asrc, st_reg.quick, st_reg.count_down};
				bpc_pkg::OFS_PRESET:  st_next.rdata = st_reg.preset;
				bpc_pkg::OFS_PREWARN: st_next.rdata = st_reg.prewarn;
				bpc_pkg::OFS_CKF:     st_next.rdata = st_reg.ckf;
				bpc_pkg::OFS_RKF:     st_next.rdata = st_reg.rkf;
				bpc_pkg::OFS_ANA_LO:  st_next.rdata = st_reg.ana_lo;
				bpc_pkg::OFS_ANA_HI:  st_next.rdata = st_reg.ana_hi;
				bpc_pkg::OFS_STATUS:  st_next.rdata = status_w;
				bpc_pkg::OFS_COUNT:   st_next.rdata = st_reg.count;
				bpc_pkg::OFS_GRAND:   st_next.rdata = st_reg.grand;
				bpc_pkg::OFS_RATE:    st_next.rdata = st_reg.rate;
				bpc_pkg::OFS_BUF:     st_next.rdata = {18'h0, st_reg.buf_lvl};
				bpc_pkg::OFS_DISPLAY: st_next.rdata = disp_val;
				default:              st_next.rdata = '0;
			endcase
		end
	end

	// State register; every field has a constant reset value
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_reg <= '0;
			st_reg.state <= bpc_pkg::ST_IDLE;
			st_reg.armed <= 1'b1;
			st_reg.win <= bpc_pkg::WIN_MIN;
			st_reg.ckf <= bpc_pkg::KF_RESET;
			st_reg.rkf <= bpc_pkg::KF_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign RDATA = st_reg.rdata;
	assign RELAYS = st_reg.relay;
	assign PULSE_OUT = st_reg.pulse;
	assign ANALOG_OUT = st_reg.ana_out;
	assign PREWARN_ORDER_ERROR = st_reg.pw_err;
	assign OUTPUT_OVERFLOW_FLAG = st_reg.overflow;
	assign LOCK_ON = st_reg.locked;
	assign PRESET_FLASH = st_reg.flash;

endmodule : bpc_core

// File: core/bpc_pkg.sv
// Constants, register map and carrier types of the batch preset counter
package bpc_pkg;

	// Timing: system clock and the one second rate tick
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned RATE_TICK_S   = 1;
	localparam int unsigned RATE_TICK_CYC = CLK_HZ * RATE_TICK_S;

	// Selectable factored output speeds and their half periods in cycles
	localparam int unsigned SPEED_HZ_0 = 10;
	localparam int unsigned SPEED_HZ_1 = 200;
	localparam int unsigned SPEED_HZ_2 = 2000;
	localparam int unsigned SPEED_HZ_3 = 20000;
	localparam int unsigned HALF_CYC_0 = CLK_HZ / (2 * SPEED_HZ_0);
	localparam int unsigned HALF_CYC_1 = CLK_HZ / (2 * SPEED_HZ_1);
	localparam int unsigned HALF_CYC_2 = CLK_HZ / (2 * SPEED_HZ_2);
	localparam int unsigned HALF_CYC_3 = CLK_HZ / (2 * SPEED_HZ_3);

	// Register byte addresses
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_PRESET  = 8'h04;
	localparam logic [7:0] OFS_PREWARN = 8'h08;
	localparam logic [7:0] OFS_CKF     = 8'h0C;
	localparam logic [7:0] OFS_RKF     = 8'h10;
	localparam logic [7:0] OFS_ANA_LO  = 8'h14;
	localparam logic [7:0] OFS_ANA_HI  = 8'h18;
	localparam logic [7:0] OFS_CMD     = 8'h1C;
	localparam logic [7:0] OFS_LOCK    = 8'h20;
	localparam logic [7:0] OFS_STATUS  = 8'h24;
	localparam logic [7:0] OFS_COUNT   = 8'h28;
	localparam logic [7:0] OFS_GRAND   = 8'h2C;
	localparam logic [7:0] OFS_RATE    = 8'h30;
	localparam logic [7:0] OFS_BUF     = 8'h34;
	localparam logic [7:0] OFS_DISPLAY = 8'h38;

	// Control register fields
	localparam int unsigned CTRL_DOWN  = 0;
	localparam int unsigned CTRL_QUICK = 1;
	localparam int unsigned CTRL_ASRC  = 2;
	localparam int unsigned CTRL_SPD   = 3;
	localparam int unsigned CTRL_WIN   = 8;

	// Scaling factor fields: mantissa and count of decimal places
	localparam int unsigned KF_MANT_W = 27;
	localparam int unsigned KF_DP     = 28;

	// Command register bits
	localparam int unsigned CMD_START = 0;
	localparam int unsigned CMD_STOP  = 1;
	localparam int unsigned CMD_CLEAR = 2;
	localparam int unsigned CMD_ENTER = 3;
	localparam int unsigned CMD_DISP  = 4;
	localparam int unsigned CMD_MENU  = 5;
	localparam int unsigned CMD_FCLR  = 6;

	// Limits and reset values
	localparam logic [31:0] COUNT_MAX = 32'h05F5_E0FF;
	localparam logic [31:0] RATE_MAX  = 32'h0098_967F;
	localparam logic [13:0] BUF_MAX   = 14'h270F;
	localparam logic [4:0]  WIN_MIN   = 5'h02;
	localparam logic [4:0]  WIN_MAX   = 5'h18;
	localparam logic [4:0]  DIV_STEPS = 5'h10;
	localparam logic [15:0] ANA_FULL  = 16'hFFFF;
	localparam logic [31:0] KF_RESET  = 32'h0000_0001;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_RUNNING = 3'b001,
		ST_STOPPED = 3'b010,
		ST_DONE    = 3'b011,
		ST_PROGRAM = 3'b100
	} bpc_state_t;

	typedef enum logic [1:0] {
		DSP_TOTAL  = 2'b00,
		DSP_RATE   = 2'b01,
		DSP_PRESET = 2'b10
	} bpc_disp_t;

	// Register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} bpc_bus_req_t;

	// Relay pair driven towards the valve drivers
	typedef struct packed {
		logic prewarn;
		logic final_out;
	} bpc_relay_t;

endpackage : bpc_pkg

// File: test/bpc_core_properties.sv
// Port checks of the batch preset counter
`timescale 1ns/10ps
module bpc_core_properties (
	// Clock, reset and requests
	input wire logic                  CLOCK,
	input wire logic                  ARST_N,
	input wire bpc_pkg::bpc_bus_req_t BUS_REQ,
	// Outputs watched
	input wire logic [31:0]           RDATA,
	input wire bpc_pkg::bpc_relay_t   RELAYS,
	input wire logic                  PULSE_OUT,
	input wire logic                  OUTPUT_OVERFLOW_FLAG,
	input wire logic                  LOCK_ON,
	input wire logic                  PRESET_FLASH
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);
	// Command write decode, shared by the relay checks
	logic cmd;
	assign cmd = BUS_REQ.wr && BUS_REQ.addr == bpc_pkg::OFS_CMD;
	sequence s_go; $past(cmd && BUS_REQ.wdata[0]); endsequence
	property p_go; $rose(RELAYS.final_out) |-> $rose(RELAYS.prewarn) ##0 s_go; endproperty
	a_go: assert property (p_go) else $error("relays rose apart");
	property p_pw; RELAYS.prewarn |-> RELAYS.final_out; endproperty
	a_pw: assert property (p_pw) else $error("prewarn outlived final");
	property p_halt; cmd && (BUS_REQ.wdata[1] || BUS_REQ.wdata[5]) |=> RELAYS == 2'b00; endproperty
	a_halt: assert property (p_halt) else $error("relays kept on stop");
	// Shortest simulated half period is ten cycles, so eight always hold
	property p_wid; $rose(PULSE_OUT) |-> PULSE_OUT[*8]; endproperty
	a_wid: assert property (p_wid) else $error("output pulse too short");
	property p_fl; $rose(PRESET_FLASH) |-> $fell(RELAYS.final_out); endproperty
	a_fl: assert property (p_fl) else $error("flash without completion");
	property p_ov; $fell(OUTPUT_OVERFLOW_FLAG) |-> $past(cmd && BUS_REQ.wdata[6]); endproperty
	a_ov: assert property (p_ov) else $error("lost flag dropped alone");
	property p_lk;
		$changed(LOCK_ON) |-> $past(BUS_REQ.wr && BUS_REQ.addr == bpc_pkg::OFS_LOCK);
	endproperty
	a_lk: assert property (p_lk) else $error("lock moved without code");
	property p_rd; !$past(BUS_REQ.rd) |-> RDATA == 32'h0000_0000; endproperty
	a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule : bpc_core_properties
bind bpc_core bpc_core_properties i_chk (.CLOCK(CLOCK), .ARST_N(ARST_N), .BUS_REQ(BUS_REQ),
	.RDATA(RDATA), .RELAYS(RELAYS), .PULSE_OUT(PULSE_OUT), .LOCK_ON(LOCK_ON),
	.OUTPUT_OVERFLOW_FLAG(OUTPUT_OVERFLOW_FLAG), .PRESET_FLASH(PRESET_FLASH));

// File: test/bpc_flow_src.sv
// Flowmeter pulse source model
`timescale 1ns/10ps
module bpc_flow_src (
	// Clock
	input wire logic CLOCK,
	// Pulse towards the counter
	output logic     FLOW_PULSE
);
	initial FLOW_PULSE = 1'b0;
	// One pulse every four cycles, faster than the output drains
	task burst(input int n);
		repeat (n) begin
			@(posedge CLOCK) FLOW_PULSE <= 1'b1;
			repeat (2) @(posedge CLOCK);
			FLOW_PULSE <= 1'b0;
			@(posedge CLOCK);
		end
	endtask : burst
endmodule : bpc_flow_src

// File: test/batch_preset_counter_tb_top.sv
// Self-checking bench of the batch preset counter
`timescale 1ns/10ps
module batch_preset_counter_tb_top;
	typedef struct packed {logic [7:0] cmd; logic [7:0] n; logic [1:0] rel;
		logic [7:0] cnt;} bpc_row_t;
	// Command, pulses, relays and count expected
	localparam bpc_row_t ROWS [8] = '{'{8'h01, 8'h0, 2'b11, 8'h0}, '{8'h00, 8'h2, 2'b01, 8'h2},
		'{8'h02, 8'h0, 2'b00, 8'h2}, '{8'h01, 8'h0, 2'b01, 8'h2}, '{8'h00, 8'h2, 2'b00, 8'h4},
		'{8'h01, 8'h3, 2'b00, 8'h7}, '{8'h04, 8'h0, 2'b00, 8'h0}, '{8'h01, 8'h0, 2'b11, 8'h0}};
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	bpc_pkg::bpc_bus_req_t req = '0;
	bpc_pkg::bpc_relay_t relays;
	logic [31:0] rdata, v;
	logic pulse_out, pw_err, lock_on, flow, ovf, flash;
	logic [15:0] ana;
	int num_errors = 0, n_compared = 0, rises = 0;
	always #5 clock = ~clock;
	// Leading edges of the factored output
	always @(posedge pulse_out) rises++;
	bpc_core #(.SEC_CYCLES(100), .HALF_10(40), .HALF_200(20), .HALF_2000(10)) i_dut (
		.CLOCK(clock), .ARST_N(arst_n), .FLOW_PULSE(flow), .BUS_REQ(req), .RDATA(rdata),
		.RELAYS(relays), .PULSE_OUT(pulse_out), .ANALOG_OUT(ana), .PREWARN_ORDER_ERROR(pw_err),
		.OUTPUT_OVERFLOW_FLAG(ovf), .LOCK_ON(lock_on), .PRESET_FLASH(flash));
	bpc_flow_src i_src (.CLOCK(clock), .FLOW_PULSE(flow));
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// Register port cycles; results settle one step after the edge
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock) req <= '{1'b1, 1'b0, a, d};
		@(posedge clock) req.wr <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clock) req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clock) req.rd <= 1'b0;
		#1 v = rdata;
	endtask : rd
	task tally_and_finish;
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (8) @(posedge clock);
		chk("reset", 32'h0, {28'h0, relays, pulse_out, lock_on});
		arst_n <= 1'b1;
		// Program speed 2000, preset 4, prewarn 2
		wr(bpc_pkg::OFS_CMD, 32'h20);
		wr(bpc_pkg::OFS_CTRL, 32'h10);
		wr(bpc_pkg::OFS_PRESET, 32'h4);
		wr(bpc_pkg::OFS_PREWARN, 32'h2);
		wr(bpc_pkg::OFS_CMD, 32'h08);
		foreach (ROWS[i]) begin
			if (ROWS[i].cmd != 8'h0) wr(bpc_pkg::OFS_CMD, {24'h0, ROWS[i].cmd});
			i_src.burst(ROWS[i].n);
			repeat (4) @(posedge clock);
			rd(bpc_pkg::OFS_COUNT);
			chk("count", {24'h0, ROWS[i].cnt}, v);
			chk("relays", {30'h0, ROWS[i].rel}, {30'h0, relays});
		end
		// Queue still held counts when the batch was cleared
		for (int k = 0; k < 400 && rises < 7; k++) @(posedge clock);
		chk("pulses", 32'h7, rises);
		rd(bpc_pkg::OFS_GRAND);
		chk("grand", 32'h7, v);
		wr(bpc_pkg::OFS_CMD, 32'h20);
		wr(bpc_pkg::OFS_PREWARN, 32'h9);
		#20 chk("order", 32'h1, {31'h0, pw_err});
		wr(bpc_pkg::OFS_LOCK, 32'h1234);
		wr(bpc_pkg::OFS_PRESET, 32'h5);
		rd(bpc_pkg::OFS_STATUS);
		chk("refused", 32'h3, {30'h0, lock_on, v[6]});
		wr(bpc_pkg::OFS_LOCK, 32'h1234);
		rd(8'h3C);
		chk("unlock", 32'h0, {31'h0, lock_on} | v);
		// Quick preset batch: flash on completion, preset typed in run state
		wr(bpc_pkg::OFS_CTRL, 32'h12);
		wr(bpc_pkg::OFS_PREWARN, 32'h2);
		wr(bpc_pkg::OFS_CMD, 32'h08);
		chk("order", 32'h0, {31'h0, pw_err});
		wr(bpc_pkg::OFS_CMD, 32'h01);
		i_src.burst(4);
		repeat (4) @(posedge clock);
		#1 chk("flash", 32'h1, {31'h0, flash});
		chk("done", 32'h0, {30'h0, relays});
		wr(bpc_pkg::OFS_PRESET, 32'h6);
		wr(bpc_pkg::OFS_CMD, 32'h08);
		wr(bpc_pkg::OFS_CMD, 32'h01);
		rd(bpc_pkg::OFS_PRESET);
		chk("preset", 32'h6, v);
		chk("restart", 32'h3, {30'h0, relays});
		chk("flash off", 32'h0, {31'h0, flash});
		// Factor 0.00011 turns two input pulses into 18181 counts and floods the queue
		wr(bpc_pkg::OFS_CMD, 32'h20);
		wr(bpc_pkg::OFS_CKF, 32'h5000_000B);
		i_src.burst(2);
		repeat (19000) @(posedge clock);
		#1 chk("lost", 32'h1, {31'h0, ovf});
		rd(bpc_pkg::OFS_GRAND);
		chk("grand", 32'h4710, v);
		wr(bpc_pkg::OFS_CMD, 32'h40);
		chk("lost clear", 32'h0, {31'h0, ovf});
		// Batch count at half the span between the end points reads half scale
		wr(bpc_pkg::OFS_CTRL, 32'h14);
		wr(bpc_pkg::OFS_ANA_HI, 32'h8E0A);
		repeat (40) @(posedge clock);
		#1 chk("analog", 32'h8000, {16'h0, ana});
		tally_and_finish();
	end
endmodule : batch_preset_counter_tb_top
